// ===== logic/timer_base_regs.vh
// Register offsets, field positions, reset values and modes of the timer.
`ifndef TIMER_BASE_REGS_VH
`define TIMER_BASE_REGS_VH

// ==========================================================================
// Register offsets (byte addresses, one word each)
// ==========================================================================
`define OFF_CTRL_A 8'h00
`define OFF_CTRL_B 8'h04
`define OFF_CTRL_E 8'h08
`define OFF_BUF_FLAGS 8'h0c
`define OFF_EV_CTRL 8'h10
`define OFF_COUNT 8'h14
`define OFF_PERIOD 8'h18
`define OFF_PER_BUF 8'h1c
`define OFF_CMP0 8'h20
`define OFF_CMP1 8'h24
`define OFF_CMP2 8'h28
`define OFF_CMP_BUF0 8'h2c
`define OFF_CMP_BUF1 8'h30
`define OFF_CMP_BUF2 8'h34
`define OFF_MATCH_FLAGS 8'h38
`define OFF_STRIDE 8'h04

// ==========================================================================
// Field positions
// ==========================================================================
`define CA_ENABLE 0
`define CA_PSEL_LO 1
`define CA_PSEL_HI 3
`define CB_WAVE_LO 0
`define CB_WAVE_HI 2
`define CB_CHEN_LO 4
`define CB_CHEN_HI 6
`define CE_DIR 0
`define CE_LOCK 1
`define BF_PER 0
`define BF_CMP_LO 1
`define BF_CMP_HI 3
`define EV_CNT_EN 0
`define MF_CMP_LO 0
`define MF_CMP_HI 2
`define MF_UPDATE 3

// ==========================================================================
// Reset values and constants
// ==========================================================================
`define PERIOD_RST 16'hffff
`define COUNT_COUNT_A 16'h0000
`define COUNT_MAX 16'hffff
`define CMP_RST 16'h0000
`define WAVE_NORMAL 3'h0
`define WAVE_FREQ 3'h1
`define WAVE_SINGLE 3'h3
`define WAVE_DUAL_LO 3'h5
`define HTRANS_NONSEQ 2'h2
`define HTRANS_SEQ 2'h3

`endif

// ===== logic/timer_base_counter_compare.v
// 16-bit timer base counter with period, three compare channels, AHB-Lite.
//
// Added by the designer: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`include "timer_base_regs.vh"
// ==========================================================================
// Notes on behaviour
// ==========================================================================

module timer_base_counter_compare (
  // Clock and reset
  input wire clk_sys,
  input wire rst_b,
  // AHB-Lite slave
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Event input, asynchronous to clk_sys
  input wire event_in,
  // Waveform pins
  output reg [2:0] wave_pin_out,
  output reg [2:0] wave_pin_oe
);

  // ========================================================================
  // Bus slave
  // ========================================================================
  // Every transfer takes one wait state, so a read issued right after a
  // write always sees the written value without a forwarding path.
  reg pend_r;
  reg pend_wr_r;
  reg [7:0] pend_addr_r;
  wire take = hsel & hready & htrans[1];
  wire wr_en = pend_r & pend_wr_r;
  wire [31:0] wd = hwdata;

  wire wr_ctrl_a = wr_en & (pend_addr_r == `OFF_CTRL_A);
  wire wr_ctrl_b = wr_en & (pend_addr_r == `OFF_CTRL_B);
  wire wr_ctrl_e = wr_en & (pend_addr_r == `OFF_CTRL_E);
  wire wr_ev = wr_en & (pend_addr_r == `OFF_EV_CTRL);
  wire wr_count = wr_en & (pend_addr_r == `OFF_COUNT);
  wire wr_period = wr_en & (pend_addr_r == `OFF_PERIOD);
  wire wr_per_buf = wr_en & (pend_addr_r == `OFF_PER_BUF);
  wire wr_mflags = wr_en & (pend_addr_r == `OFF_MATCH_FLAGS);

  // ========================================================================
  // Control registers
  // ========================================================================
  reg enable_r;
  reg [2:0] prescaler_select_r;
  reg [2:0] waveform_mode_select_r;
  reg [2:0] compare_channel_enable_r;
  reg dir_down_r;
  reg lock_update_r;
  reg event_count_input_enable_r;
  reg [15:0] count_r;
  reg [15:0] period_r;
  reg [15:0] period_buffer_r;
  reg period_buffer_valid_r;
  reg update_flag_r;

  wire mode_freq = (waveform_mode_select_r == `WAVE_FREQ);
  wire mode_dual = (waveform_mode_select_r >= `WAVE_DUAL_LO);
  wire mode_wave = (waveform_mode_select_r != `WAVE_NORMAL);

  // ========================================================================
  // Prescaler and event input
  // ========================================================================
  reg [9:0] pre_cnt_r;
  reg [9:0] pre_mask;
  reg ev_s1_r;
  reg ev_s2_r;
  reg ev_s3_r;

  always @* begin
    case (prescaler_select_r)
      3'h0: pre_mask = 10'h000;
      3'h1: pre_mask = 10'h001;
      3'h2: pre_mask = 10'h003;
      3'h3: pre_mask = 10'h007;
      3'h4: pre_mask = 10'h00f;
      3'h5: pre_mask = 10'h03f;
      3'h6: pre_mask = 10'h0ff;
      default: pre_mask = 10'h3ff;
    endcase
  end

  wire pre_tick = ((pre_cnt_r & pre_mask) == pre_mask);
  wire ev_rise = ev_s2_r & ~ev_s3_r;
  // The timer tick: prescaled clock or events, only while enabled.
  wire tick = enable_r &
    (event_count_input_enable_r ? ev_rise : pre_tick);

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      pre_cnt_r <= 10'h000;
      ev_s1_r <= 1'b0;
      ev_s2_r <= 1'b0;
      ev_s3_r <= 1'b0;
    end else begin
      ev_s1_r <= event_in;
      ev_s2_r <= ev_s1_r;
      ev_s3_r <= ev_s2_r;
      if (enable_r) begin
        pre_cnt_r <= pre_cnt_r + 10'h001;
      end else begin
        pre_cnt_r <= 10'h000;
      end
    end
  end

  // ========================================================================
  // Base counter: top, count_a and update condition
  // ========================================================================
  wire [15:0] cmp0_w;
  wire [15:0] top_val = mode_freq ? cmp0_w : period_r;
  wire at_count_a = (count_r == `COUNT_COUNT_A);
  wire at_max = (count_r == `COUNT_MAX);
  wire at_top = (count_r == top_val);
  // Dual-slope updates at count_a; otherwise at the end of the direction.
  wire update_cond = tick & (mode_dual ? (at_count_a & dir_down_r) :
    (dir_down_r ? at_count_a : at_top));
  wire do_update = update_cond & ~lock_update_r;

  reg [15:0] count_nxt;
  reg dir_nxt;
  always @* begin
    count_nxt = count_r;
    dir_nxt = dir_down_r;
    if (tick) begin
      if (!dir_down_r) begin
        if (at_top && mode_dual) begin
          dir_nxt = 1'b1;
          count_nxt = count_r - 16'h0001;
        end else if (at_top) begin
          count_nxt = `COUNT_COUNT_A;
        end else if (at_max) begin
          count_nxt = `COUNT_COUNT_A;
        end else begin
          count_nxt = count_r + 16'h0001;
        end
      end else begin
        if (at_count_a && mode_dual) begin
          dir_nxt = 1'b0;
          count_nxt = count_r + 16'h0001;
        end else if (at_count_a) begin
          count_nxt = period_r;
        end else begin
          count_nxt = count_r - 16'h0001;
        end
      end
    end
    if (wr_ctrl_e) begin
      dir_nxt = wd[`CE_DIR];
    end
    if (wr_count) begin
      count_nxt = wd[15:0];
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      enable_r <= 1'b0;
      prescaler_select_r <= 3'h0;
      waveform_mode_select_r <= `WAVE_NORMAL;
      compare_channel_enable_r <= 3'h0;
      dir_down_r <= 1'b0;
      lock_update_r <= 1'b0;
      event_count_input_enable_r <= 1'b0;
      count_r <= `COUNT_COUNT_A;
      period_r <= `PERIOD_RST;
      period_buffer_r <= `PERIOD_RST;
      period_buffer_valid_r <= 1'b0;
      update_flag_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      dir_down_r <= dir_nxt;
      if (wr_ctrl_a) begin
        enable_r <= wd[`CA_ENABLE];
        prescaler_select_r <= wd[`CA_PSEL_HI:`CA_PSEL_LO];
      end
      if (wr_ctrl_b) begin
        waveform_mode_select_r <= wd[`CB_WAVE_HI:`CB_WAVE_LO];
        compare_channel_enable_r <= wd[`CB_CHEN_HI:`CB_CHEN_LO];
      end
      if (wr_ctrl_e) begin
        lock_update_r <= wd[`CE_LOCK];
      end
      if (wr_ev) begin
        event_count_input_enable_r <= wd[`EV_CNT_EN];
      end
      if (do_update && period_buffer_valid_r) begin
        period_r <= period_buffer_r;
      end
      if (wr_period) begin
        period_r <= wd[15:0];
      end
      // A buffer write in the update cycle keeps its flag: set wins.
      if (wr_per_buf) begin
        period_buffer_r <= wd[15:0];
        period_buffer_valid_r <= 1'b1;
      end else if (do_update) begin
        period_buffer_valid_r <= 1'b0;
      end
      if (update_cond) begin
        update_flag_r <= 1'b1;
      end else if (wr_mflags && wd[`MF_UPDATE]) begin
        update_flag_r <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Compare channels
  // ========================================================================
  wire [15:0] cmp_w [0:2];
  wire [15:0] cbuf_w [0:2];
  wire [2:0] cbv_w;
  wire [2:0] flag_w;
  wire [2:0] wave_w;
  assign cmp0_w = cmp_w[0];

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_chan
      reg [15:0] compare_value_r;
      reg [15:0] compare_buffer_r;
      reg compare_buffer_valid_r;
      reg flag_r;
      reg wave_r;
      wire [31:0] off_c = `OFF_CMP0 + `OFF_STRIDE * gi;
      wire [31:0] off_b = `OFF_CMP_BUF0 + `OFF_STRIDE * gi;
      wire wr_c = wr_en & (pend_addr_r == off_c[7:0]);
      wire wr_b = wr_en & (pend_addr_r == off_b[7:0]);
      // Match is taken on a tick against the compare in use for this count.
      wire match = tick & (count_r == compare_value_r);
      assign cmp_w[gi] = compare_value_r;
      assign cbuf_w[gi] = compare_buffer_r;
      assign cbv_w[gi] = compare_buffer_valid_r;
      assign flag_w[gi] = flag_r;
      assign wave_w[gi] = wave_r;

      always @(posedge clk_sys) begin
        if (!rst_b) begin
          compare_value_r <= `CMP_RST;
          compare_buffer_r <= `CMP_RST;
          compare_buffer_valid_r <= 1'b0;
          flag_r <= 1'b0;
          wave_r <= 1'b0;
        end else begin
          if (wr_c) begin
            compare_value_r <= wd[15:0];
          end else if (do_update && compare_buffer_valid_r) begin
            compare_value_r <= compare_buffer_r;
          end
          if (wr_b) begin
            compare_buffer_r <= wd[15:0];
            compare_buffer_valid_r <= 1'b1;
          end else if (do_update) begin
            compare_buffer_valid_r <= 1'b0;
          end
          if (match) begin
            flag_r <= 1'b1;
          end else if (wr_mflags && wd[`MF_CMP_LO + gi]) begin
            flag_r <= 1'b0;
          end
          if (tick) begin
            if (mode_freq) begin
              if (match) begin
                wave_r <= ~wave_r;
              end
            end else if (mode_dual) begin
              if (match) begin
                wave_r <= dir_down_r;
              end else if (at_count_a) begin
                wave_r <= 1'b1;
              end
            end else if (mode_wave) begin
              if (match) begin
                wave_r <= 1'b0;
              end else if (at_count_a) begin
                wave_r <= 1'b1;
              end
            end
          end
        end
      end
    end
  endgenerate

  // ========================================================================
  // Pin override and bus read path
  // ========================================================================
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    case (pend_addr_r)
      `OFF_CTRL_A: rd_mux = {28'h0000000, prescaler_select_r, enable_r};
      `OFF_CTRL_B: rd_mux = {25'h0000000, compare_channel_enable_r,
        1'b0, waveform_mode_select_r};
      `OFF_CTRL_E: rd_mux = {30'h00000000, lock_update_r, dir_down_r};
      `OFF_BUF_FLAGS: rd_mux = {28'h0000000, cbv_w, period_buffer_valid_r};
      `OFF_EV_CTRL: rd_mux = {31'h00000000, event_count_input_enable_r};
      `OFF_COUNT: rd_mux = {16'h0000, count_r};
      `OFF_PERIOD: rd_mux = {16'h0000, period_r};
      `OFF_PER_BUF: rd_mux = {16'h0000, period_buffer_r};
      `OFF_CMP0: rd_mux = {16'h0000, cmp_w[0]};
      `OFF_CMP1: rd_mux = {16'h0000, cmp_w[1]};
      `OFF_CMP2: rd_mux = {16'h0000, cmp_w[2]};
      `OFF_CMP_BUF0: rd_mux = {16'h0000, cbuf_w[0]};
      `OFF_CMP_BUF1: rd_mux = {16'h0000, cbuf_w[1]};
      `OFF_CMP_BUF2: rd_mux = {16'h0000, cbuf_w[2]};
      `OFF_MATCH_FLAGS: rd_mux = {28'h0000000, update_flag_r, flag_w};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      pend_r <= 1'b0;
      pend_wr_r <= 1'b0;
      pend_addr_r <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wave_pin_out <= 3'h0;
      wave_pin_oe <= 3'h0;
    end else begin
      hresp <= 1'b0;
      if (pend_r) begin
        pend_r <= 1'b0;
        hreadyout <= 1'b1;
        if (!pend_wr_r) begin
          hrdata <= rd_mux;
        end
      end else if (take) begin
        pend_r <= 1'b1;
        pend_wr_r <= hwrite;
        pend_addr_r <= {haddr[7:2], 2'b00};
        hreadyout <= 1'b0;
      end
      wave_pin_oe <= compare_channel_enable_r & {3{mode_wave}};
      wave_pin_out <= wave_w & compare_channel_enable_r &
        {3{mode_wave}};
    end
  end

endmodule // timer_base_counter_compare

// ===== sim/timer_base_counter_compare_props.sv
// Checker of bus timing, read data and pin gating of the timer.
`timescale 1ns/1ps
module timer_props (
  // Clock and reset
  input wire clk_sys,
  input wire rst_b,
  // Bus
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  // Event and pins
  input wire event_in,
  input wire [2:0] wave_pin_out,
  input wire [2:0] wave_pin_oe
);
  // ====================
  // Helper logic
  // ====================
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire taken = hsel & hready & htrans[1] & hreadyout;
  reg rd_r;
  reg un_r;
  reg cb_r;
  // Age of the last mode write, saturating so it never wraps back to zero.
  reg [2:0] cb_age_r;
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      rd_r <= 1'b0;
      un_r <= 1'b0;
      cb_r <= 1'b0;
      cb_age_r <= 3'h7;
    end else begin
      rd_r <= taken & !hwrite;
      un_r <= taken & !hwrite & (haddr >= 8'h3c);
      if (taken & hwrite & (haddr[7:2] == 6'h01)) begin
        cb_r <= 1'b1;
        cb_age_r <= 3'h0;
      end else if (cb_age_r != 3'h7) begin
        cb_age_r <= cb_age_r + 3'h1;
      end
    end
  end
  // ====================
  // Assertions
  // ====================
  xfer_one_wait_a: assert property (
    taken |=> !hreadyout ##1 hreadyout) else $error("bad wait state");
  wait_short_a: assert property (
    !hreadyout |=> hreadyout) else $error("wait too long");
  wait_cause_a: assert property (
    $fell(hreadyout) |-> $past(taken)) else $error("stray wait");
  okay_resp_a: assert property (
    hresp == 1'b0) else $error("error response");
  rdata_cause_a: assert property (
    $changed(hrdata) |-> $past(rd_r)) else $error("read data moved");
  unmapped_zero_a: assert property (
    un_r |=> hrdata == 32'h0) else $error("unmapped read not zero");
  pin_gate_a: assert property (
    (wave_pin_out & ~wave_pin_oe) == 3'h0) else $error("pin not gated");
  oe_cause_a: assert property (
    $changed(wave_pin_oe) |-> cb_age_r <= 3'h4) else $error("oe moved");
  oe_idle_a: assert property (
    !cb_r |-> wave_pin_oe == 3'h0) else $error("oe without mode");
endmodule // timer_props

bind timer_base_counter_compare timer_props i_props (
  .clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
  .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .event_in(event_in), .wave_pin_out(wave_pin_out),
  .wave_pin_oe(wave_pin_oe));

// ===== sim/timer_far_side.sv
// Far-side model: event source and the pin levels seen at the port.
`timescale 1ns/1ps
module timer_far_side (
  // Clock
  input wire clk_sys,
  // Waveform pins
  input wire [2:0] wave_pin_out,
  input wire [2:0] wave_pin_oe,
  // Event line and pin levels
  output reg event_in,
  output wire [2:0] pin_level
);
  // ====================
  // Model
  // ====================
  // A pin the timer does not drive falls to the port's pull-down level.
  assign pin_level = wave_pin_out & wave_pin_oe;
  initial event_in = 1'b0;
  // Two cycles high and two low keeps each level past the synchroniser.
  task send(input integer n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        event_in <= 1'b1;
        repeat (2) @(posedge clk_sys);
        event_in <= 1'b0;
        repeat (2) @(posedge clk_sys);
      end
    end
  endtask
endmodule // timer_far_side

// ===== sim/timer_base_counter_compare_tb.sv
// Testbench of the timer through its bus and event line.
`timescale 1ns/1ps
module timer_base_counter_compare_tb;
  // ====================
  // Signals
  // ====================
  reg clk_sys = 1'b0;
  reg rst_b = 1'b0;
  reg hsel;
  reg [7:0] haddr;
  reg [1:0] htrans;
  reg hwrite;
  reg [2:0] hsize;
  reg [31:0] hwdata;
  wire [31:0] hrdata;
  wire hreadyout;
  wire hresp;
  wire event_in;
  wire [2:0] wave_pin_out;
  wire [2:0] wave_pin_oe;
  wire [2:0] pin_level;
  integer fails = 0;
  integer n_compared = 0;
  integer i;
  reg [31:0] q;
  int dv [8] = '{1, 2, 4, 8, 16, 64, 256, 1024};
  logic [6:0] cb [4] = '{7'h70, 7'h11, 7'h63, 7'h75};
  logic [2:0] oe [4] = '{3'h0, 3'h1, 3'h6, 3'h7};

  always #20 clk_sys = ~clk_sys;

  timer_base_counter_compare i_dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .event_in(event_in), .wave_pin_out(wave_pin_out),
    .wave_pin_oe(wave_pin_oe));
  timer_far_side i_far (.clk_sys(clk_sys), .wave_pin_out(wave_pin_out),
    .wave_pin_oe(wave_pin_oe), .event_in(event_in),
    .pin_level(pin_level));

  // ====================
  // Tasks
  // ====================
  task results;
    begin
      $display("Compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  task chk(input logic [31:0] s, input logic [31:0] e);
    begin
      n_compared = n_compared + 1;
      if (s !== e) begin
        fails = fails + 1;
        $display("Error at %0t: got %h, want %h", $time, s, e);
      end
    end
  endtask

  // Called just after a rising edge; returns at the edge taking the data.
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer k;
    begin
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      hsize <= 3'h2;
      htrans <= 2'h2;
      k = 0;
      do begin
        @(posedge clk_sys);
        k = k + 1;
      end while (hreadyout !== 1'b1 && k < 40);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do begin
        @(posedge clk_sys);
        k = k + 1;
      end while (hreadyout !== 1'b1 && k < 40);
      q = hrdata;
      if (k >= 40) begin
        fails = fails + 1;
        $display("Error at %0t: bus timeout", $time);
        results;
      end
    end
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    begin
      xfer(1'b0, a, 32'h0);
      chk(q, e);
    end
  endtask

  initial begin
    repeat (60000) @(posedge clk_sys);
    fails = fails + 1;
    $display("Error at %0t: run did not finish", $time);
    results;
  end

  // ====================
  // Tests
  // ====================
  initial begin
    hsel <= 1'b0;
    haddr <= 8'h00;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hsize <= 3'h2;
    hwdata <= 32'h0;
    repeat (3) @(posedge clk_sys);
    chk({27'h0, hreadyout, hresp, wave_pin_oe}, 32'h10);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    rd(8'h18, 32'hffff);
    rd(8'h14, 32'h0);
    rd(8'h3c, 32'h0);
    xfer(1'b1, 8'h0c, 32'hf);
    rd(8'h0c, 32'h0);
    $display("Test reset finished");
    xfer(1'b1, 8'h10, 32'h1);
    xfer(1'b1, 8'h18, 32'h3);
    xfer(1'b1, 8'h14, 32'h2);
    xfer(1'b1, 8'h00, 32'h1);
    repeat (20) @(posedge clk_sys);
    rd(8'h14, 32'h2);
    i_far.send(1);
    rd(8'h14, 32'h3);
    i_far.send(1);
    rd(8'h14, 32'h0);
    xfer(1'b1, 8'h08, 32'h1);
    i_far.send(1);
    rd(8'h14, 32'h3);
    i_far.send(1);
    rd(8'h14, 32'h2);
    xfer(1'b1, 8'h14, 32'h1);
    rd(8'h14, 32'h1);
    xfer(1'b1, 8'h00, 32'h0);
    i_far.send(2);
    rd(8'h14, 32'h1);
    $display("Test events finished");
    xfer(1'b1, 8'h08, 32'h2);
    xfer(1'b1, 8'h1c, 32'h2);
    xfer(1'b1, 8'h30, 32'h5);
    rd(8'h0c, 32'h5);
    xfer(1'b1, 8'h00, 32'h1);
    i_far.send(3);
    rd(8'h18, 32'h3);
    rd(8'h0c, 32'h5);
    xfer(1'b1, 8'h08, 32'h0);
    i_far.send(4);
    rd(8'h18, 32'h2);
    rd(8'h24, 32'h5);
    rd(8'h0c, 32'h0);
    xfer(1'b0, 8'h38, 32'h0);
    chk({31'h0, q[3]}, 32'h1);
    $display("Test buffering finished");
    xfer(1'b1, 8'h00, 32'h0);
    xfer(1'b1, 8'h38, 32'hf);
    rd(8'h38, 32'h0);
    xfer(1'b1, 8'h20, 32'h2);
    xfer(1'b1, 8'h28, 32'h9);
    rd(8'h0c, 32'h0);
    xfer(1'b1, 8'h18, 32'h7);
    rd(8'h18, 32'h7);
    xfer(1'b1, 8'h14, 32'h0);
    xfer(1'b1, 8'h00, 32'h1);
    i_far.send(3);
    rd(8'h38, 32'h1);
    xfer(1'b1, 8'h18, 32'h1);
    xfer(1'b1, 8'h14, 32'hfffe);
    i_far.send(2);
    rd(8'h14, 32'h0);
    $display("Test compare finished");
    xfer(1'b1, 8'h10, 32'h0);
    xfer(1'b1, 8'h18, 32'hffff);
    for (i = 0; i < 8; i = i + 1) begin
      xfer(1'b1, 8'h00, 32'h0);
      xfer(1'b1, 8'h14, 32'h0);
      xfer(1'b1, 8'h00, {28'h0, i[2:0], 1'b1});
      repeat (2048) @(posedge clk_sys);
      xfer(1'b1, 8'h00, 32'h0);
      xfer(1'b0, 8'h14, 32'h0);
      chk({31'h0, q >= 2048 / dv[i] && q <= 2048 / dv[i] + 4}, 1);
    end
    $display("Test prescaler finished");
    for (i = 0; i < 4; i = i + 1) begin
      xfer(1'b1, 8'h04, {25'h0, cb[i]});
      repeat (3) @(posedge clk_sys);
      chk({29'h0, wave_pin_oe}, {29'h0, oe[i]});
    end
    $display("Test pins finished");
    // Single-slope on channel 0: set at count_a, cleared on the match.
    xfer(1'b1, 8'h10, 32'h1);
    xfer(1'b1, 8'h04, 32'h13);
    xfer(1'b1, 8'h18, 32'h3);
    xfer(1'b1, 8'h20, 32'h2);
    xfer(1'b1, 8'h14, 32'h0);
    xfer(1'b1, 8'h00, 32'h1);
    i_far.send(1);
    repeat (2) @(posedge clk_sys);
    chk({26'h0, pin_level, wave_pin_out}, 32'h9);
    i_far.send(2);
    repeat (2) @(posedge clk_sys);
    chk({26'h0, pin_level, wave_pin_out}, 32'h0);
    $display("Test waveform finished");
    results;
  end
endmodule // timer_base_counter_compare_tb
